// ==== rtl/pixel_fifo_pkg.sv ====
// Purpose: shared constants and types of the pixel output port
// Assumes: 16-bit video words, 32-bit Wishbone register bus
// Notes:   ctrl and irq register fields are laid out by the packed structs below
`default_nettype none
package pixel_fifo_pkg;
   // =====================================================================
   // fifo geometry and flag levels
   localparam int FIFO_DEPTH = 40;
   localparam int DATA_W     = 16;
   localparam int CNT_W      = 6;
   localparam int AE_LIMIT   = 9;   // almost empty below this many
   localparam int AF_LIMIT   = 32;  // almost full above this many
   localparam int HALF_LIMIT = 20;  // half full level
   localparam int DV_THR     = 20;  // data valid rising level
   localparam int AE_PIPE    = 2;   // almost-empty output pipeline stages

   // =====================================================================
   // register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

   // =====================================================================
   // embedded control codes
   localparam logic [15:0] CODE_LINE  = 16'hFF01;
   localparam logic [15:0] CODE_FIELD = 16'hFF02;

   // =====================================================================
   // register layouts
   typedef struct packed {
      logic inv_af;         // invert almost_full_flag
      logic inv_dv;         // invert data_valid_flag
      logic af_half;        // almost full flags half full instead
      logic dv_thr_full;    // async data valid rises at almost full level
      logic sync_variant2;  // embedded codes in synchronous mode
      logic bus16;          // 1: 16-bit bus, 0: 8-bit bus
      logic async_mode;     // asynchronous pixel mode
   } ctrl_t;
   localparam ctrl_t CTRL_RESET = 7'h02;

   typedef struct packed {
      logic underrun;       // read request while empty
      logic ae_rise;        // almost empty became true
      logic af_rise;        // almost full became true
   } irq_t;
   localparam irq_t IRQ_RESET = 3'h0;

   typedef enum logic [1:0] {
      SYNC_IDLE = 2'b00,
      SYNC_LOW  = 2'b01
   } sync_state_t;
endpackage
`default_nettype wire

// ==== rtl/pixel_output_fifo_port.sv ====
// Purpose: pixel output port with output fifo, flags and markers
// Assumes: pixel stream and markers arrive on core_clk; read clock is sampled
// Notes:   pixel clocks are divided from core_clk
// Behaviour
// - 16-bit uses the whole bus; 8-bit uses upper byte
// - sync launch on 1x clock or 2x clock
// - sync variant 2 embeds control codes
// - async mode 16-bit only, on read clock
// - async always inserts line and field codes
// - sync data valid only on valid pixels and embedded control codes
// - occupancy counts pixels and control codes
// - almost empty below 9 entries
// - almost empty passes an output pipeline
// - almost full above 32 entries
// - setting makes almost full flag half full
// - polarity of valid and almost full programmable
// - pointer reset low clears both pointers
`timescale 1ns/10ps
`default_nettype none
module pixel_output_fifo_port #(
   parameter int DEPTH = pixel_fifo_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                              core_clk,
   input  wire logic                              rst_b,
   // wishbone slave
   input  wire logic                              cyc_i,
   input  wire logic                              stb_i,
   input  wire logic                              we_i,
   input  wire logic [7:0]                        adr_i,
   input  wire logic [3:0]                        sel_i,
   input  wire logic [31:0]                       dat_i,
   output logic      [31:0]                       dat_o,
   output logic                                   ack_o,
   output logic                                   irq,
   // pixel stream from the video pipeline
   input  wire logic                              pix_valid,
   input  wire logic [pixel_fifo_pkg::DATA_W-1:0] pix_data,
   output logic                                   pix_ready,
   input  wire logic                              line_start_marker,
   input  wire logic                              field_start_marker,
   // video port pins
   output logic [pixel_fifo_pkg::DATA_W-1:0]      video_data_bus,
   output logic                                   data_valid_flag,
   output logic                                   almost_empty_flag,
   output logic                                   almost_full_flag,
   output logic                                   pixel_clock_1x,
   output logic                                   pixel_clock_2x,
   input  wire logic                              fifo_read_clock,
   input  wire logic                              fifo_read_enable,
   input  wire logic                              fifo_pointer_reset
);
   import pixel_fifo_pkg::*;

   ctrl_t                     ctrl;
   irq_t                      irq_stat;
   irq_t                      irq_mask;
   irq_t                      irq_event;
   sync_state_t               sync_state;
   logic [DATA_W-1:0]         mem [DEPTH];
   logic [CNT_W-1:0]          wr_ptr;
   logic [CNT_W-1:0]          rd_ptr;
   logic [CNT_W-1:0]          count;
   logic                      ptr_rst_b;
   logic [1:0]                clk_div;
   logic                      tick_1x;
   logic                      tick_2x;
   logic                      launch;
   logic                      rclk_meta;
   logic                      rclk_sync;
   logic                      rclk_prev;
   logic                      ren_meta;
   logic                      ren_sync;
   logic                      rd_edge;
   logic                      pop;
   logic                      push;
   logic                      pend_line;
   logic                      pend_field;
   logic                      use_codes;
   logic [DATA_W-1:0]         next_word;
   logic                      have_word;
   logic                      take_word;
   logic [7:0]                low_byte;
   logic                      sync_dv;
   logic                      async_dv;
   logic [AE_PIPE-1:0]        ae_pipe;
   logic                      ae_raw;
   logic                      af_raw;
   logic                      af_prev;
   logic                      ae_prev;
   logic                      bus_read;

   // =====================================================================
   // pixel clocks and launch ticks
   // the tick marks the core edge at which the chosen pixel clock rises
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_div <= 2'h0;
      end else begin
         clk_div <= clk_div + 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pixel_clock_2x <= 1'b0;
         pixel_clock_1x <= 1'b0;
      end else begin
         pixel_clock_2x <= ~clk_div[0];
         pixel_clock_1x <= (clk_div == 2'h1) || (clk_div == 2'h2);
      end
   end

   assign tick_2x = (clk_div[0] == 1'b0);
   assign tick_1x = (clk_div == 2'h1);
   assign launch  = ctrl.bus16 ? tick_1x : tick_2x;

   // =====================================================================
   // read clock and read enable synchronisers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rclk_meta <= 1'b0;
         rclk_sync <= 1'b0;
         rclk_prev <= 1'b0;
         ren_meta  <= 1'b0;
         ren_sync  <= 1'b0;
      end else begin
         rclk_meta <= fifo_read_clock;
         rclk_sync <= rclk_meta;
         rclk_prev <= rclk_sync;
         ren_meta  <= fifo_read_enable;
         ren_sync  <= ren_meta;
      end
   end

   // reads only count in async mode; a reader holding the clock low is inert
   assign rd_edge = ctrl.async_mode && rclk_sync && !rclk_prev;
   assign pop     = rd_edge && ren_sync && (count != '0);

   // =====================================================================
   // marker capture and word selection
   assign use_codes = ctrl.async_mode || ctrl.sync_variant2;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_line  <= 1'b0;
         pend_field <= 1'b0;
      end else begin
         // a new marker in the cycle of consumption is kept
         if (line_start_marker && use_codes) begin
            pend_line <= 1'b1;
         end else if ((take_word && pend_line) || !use_codes) begin
            pend_line <= 1'b0;
         end
         if (field_start_marker && use_codes) begin
            pend_field <= 1'b1;
         end else if ((take_word && !pend_line && pend_field) || !use_codes) begin
            pend_field <= 1'b0;
         end
      end
   end

   always_comb begin
      if (pend_line) begin
         next_word = CODE_LINE;
      end else if (pend_field) begin
         next_word = CODE_FIELD;
      end else begin
         next_word = pix_data;
      end
   end

   assign have_word = pend_line || pend_field || pix_valid;
   assign push      = ctrl.async_mode && have_word && (count != DEPTH[CNT_W-1:0]);
   assign take_word = ctrl.async_mode ? push
                    : (have_word && launch && (sync_state == SYNC_IDLE));
   // a marker word steals the slot, so the pixel waits
   assign pix_ready = take_word && !pend_line && !pend_field;

   // =====================================================================
   // fifo storage and pointers
   // external pointer reset acts without the clock, as does core reset
   assign ptr_rst_b = rst_b && fifo_pointer_reset;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= next_word;
      end
   end

   always_ff @(posedge core_clk or negedge ptr_rst_b) begin
      if (!ptr_rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == CNT_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == CNT_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         // every stored word counts, codes included
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

   // =====================================================================
   // synchronous output path
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_state <= SYNC_IDLE;
         low_byte   <= 8'h00;
      end else begin
         case (sync_state)
            SYNC_IDLE: begin
               if (take_word && !ctrl.async_mode && !ctrl.bus16) begin
                  low_byte   <= next_word[7:0];
                  sync_state <= SYNC_LOW;
               end
            end
            SYNC_LOW: begin
               if (launch || ctrl.async_mode) begin
                  sync_state <= SYNC_IDLE;
               end
            end
            default: begin
               sync_state <= SYNC_IDLE;
            end
         endcase
      end
   end

   // bus data, both modes share one register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         video_data_bus <= '0;
         sync_dv        <= 1'b0;
      end else if (ctrl.async_mode) begin
         sync_dv <= 1'b0;
         if (pop) begin
            video_data_bus <= mem[rd_ptr];
         end
      end else if (launch) begin
         // valid stands for one pixel clock period
         sync_dv <= take_word || (sync_state == SYNC_LOW);
         if (sync_state == SYNC_LOW) begin
            video_data_bus <= {low_byte, 8'h00};
         end else if (take_word) begin
            video_data_bus <= ctrl.bus16 ? next_word
                                         : {next_word[15:8], 8'h00};
         end
      end
   end

   // =====================================================================
   // fifo flags
   assign ae_raw = (count < CNT_W'(AE_LIMIT));
   assign af_raw = ctrl.af_half ? (count >= CNT_W'(HALF_LIMIT))
                                 : (count > CNT_W'(AF_LIMIT));

   // pipeline lags live occupancy; readers must stop at once
   always_ff @(posedge core_clk or negedge ptr_rst_b) begin
      if (!ptr_rst_b) begin
         ae_pipe <= '1;
      end else begin
         ae_pipe <= {ae_pipe[AE_PIPE-2:0], ae_raw};
      end
   end

   always_ff @(posedge core_clk or negedge ptr_rst_b) begin
      if (!ptr_rst_b) begin
         async_dv <= 1'b0;
      end else if (count == '0) begin
         async_dv <= 1'b0;
      end else if (count >= (ctrl.dv_thr_full ? CNT_W'(AF_LIMIT)
                                              : CNT_W'(DV_THR))) begin
         async_dv <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_valid_flag   <= 1'b0;
         almost_empty_flag <= 1'b1;
         almost_full_flag  <= 1'b0;
      end else begin
         data_valid_flag   <= (ctrl.async_mode ? async_dv : sync_dv) ^ ctrl.inv_dv;
         almost_empty_flag <= ae_pipe[AE_PIPE-1];
         almost_full_flag  <= af_raw ^ ctrl.inv_af;
      end
   end

   // =====================================================================
   // interrupt events
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         af_prev <= 1'b0;
         ae_prev <= 1'b1;
      end else begin
         af_prev <= af_raw;
         ae_prev <= ae_pipe[AE_PIPE-1];
      end
   end

   assign irq_event.af_rise  = af_raw && !af_prev;
   assign irq_event.ae_rise  = ae_pipe[AE_PIPE-1] && !ae_prev;
   assign irq_event.underrun = rd_edge && ren_sync && (count == '0);

   assign bus_read = cyc_i && stb_i && !we_i && ack_o && (adr_i == REG_IRQ_STAT);

   // set wins over the read clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat <= IRQ_RESET;
      end else begin
         irq_stat <= (bus_read ? IRQ_RESET : irq_stat) | irq_event;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // =====================================================================
   // wishbone register slave, one wait state
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl     <= CTRL_RESET;
         irq_mask <= IRQ_RESET;
      end else if (cyc_i && stb_i && we_i && ack_o && sel_i[0]) begin
         if (adr_i == REG_CTRL) begin
            ctrl <= ctrl_t'(dat_i[$bits(ctrl_t)-1:0]);
         end
         if (adr_i == REG_IRQ_MASK) begin
            irq_mask <= irq_t'(dat_i[$bits(irq_t)-1:0]);
         end
      end
   end

   // unmapped addresses read zero and ignore writes
   always_comb begin
      case (adr_i)
         REG_CTRL:     dat_o = {25'h0, ctrl};
         REG_STATUS:   dat_o = {20'h0, async_dv, ae_pipe[AE_PIPE-1], af_raw,
                                (count == '0), 2'h0, count};
         REG_IRQ_STAT: dat_o = {29'h0, irq_stat};
         REG_IRQ_MASK: dat_o = {29'h0, irq_mask};
         default:      dat_o = 32'h0;
      endcase
   end
endmodule
`default_nettype wire

// ==== tb/pixel_output_fifo_port_sva.sv ====
// Purpose: port checks of the pixel output fifo port
// Assumes: a shadow of ctrl follows acked bus writes
// Notes:   flag checks wait until ctrl has been quiet three cycles
`timescale 1ns/10ps
`default_nettype none
module pixel_output_fifo_port_sva #(
   parameter int DEPTH = pixel_fifo_pkg::FIFO_DEPTH
) (
   // clock, reset and bus
   input wire logic                              core_clk,
   input wire logic                              rst_b,
   input wire logic                              cyc_i,
   input wire logic                              stb_i,
   input wire logic                              we_i,
   input wire logic [7:0]                        adr_i,
   input wire logic [3:0]                        sel_i,
   input wire logic [31:0]                       dat_i,
   input wire logic                              ack_o,
   // pixel side
   input wire logic                              pix_valid,
   input wire logic [pixel_fifo_pkg::DATA_W-1:0] video_data_bus,
   input wire logic                              data_valid_flag,
   input wire logic                              almost_empty_flag,
   input wire logic                              almost_full_flag,
   input wire logic                              fifo_read_clock,
   input wire logic                              fifo_pointer_reset
);
   import pixel_fifo_pkg::*;
   ctrl_t      mode;
   logic [1:0] calm;
   logic       rclk_d;
   logic [3:0] since;
   logic       steady;
   logic       dv_on;
   logic       af_on;
   assign steady = (calm == 2'h3);
   assign dv_on  = data_valid_flag ^ mode.inv_dv;
   assign af_on  = almost_full_flag ^ mode.inv_af;
   // =====================================================================
   // ctrl shadow; flags lag a write, so judge them only once it settles
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode <= CTRL_RESET;
         calm <= 2'h0;
      end else if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == REG_CTRL) begin
         mode <= ctrl_t'(dat_i[6:0]);
         calm <= 2'h0;
      end else if (calm != 2'h3) begin
         calm <= calm + 2'h1;
      end
   end
   // cycles since the read clock pin last rose
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rclk_d <= 1'b0;
         since  <= 4'hF;
      end else begin
         rclk_d <= fifo_read_clock;
         since  <= (fifo_read_clock && !rclk_d) ? 4'h0 : ((since == 4'hF) ? 4'hF : since + 4'h1);
      end
   end
   // =====================================================================
   // properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_quiet;
      (steady && !pix_valid && !mode.async_mode && !mode.sync_variant2) [*8];
   endsequence
   property p_ack_resp;
      s_req |=> ack_o;
   endproperty
   property p_ack_one;
      ack_o |=> !ack_o;
   endproperty
   property p_lsb8;
      steady && !mode.bus16 && !mode.async_mode && $changed(video_data_bus) |-> video_data_bus[7:0] == 8'h00;
   endproperty
   property p_async_bus;
      steady && mode.async_mode && $changed(video_data_bus) |-> since <= 4'h6;
   endproperty
   property p_sync_quiet;
      s_quiet |=> !dv_on;
   endproperty
   property p_dv_rise;
      steady && mode.async_mode && $rose(dv_on) |-> !almost_empty_flag;
   endproperty
   property p_full;
      steady && af_on && fifo_pointer_reset && $past(fifo_pointer_reset) |-> !almost_empty_flag;
   endproperty
   property p_ptr_clear;
      steady && !fifo_pointer_reset ##1 !fifo_pointer_reset |-> almost_empty_flag && !af_on
         && (!mode.async_mode || !dv_on);
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("request not acked next cycle");
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   a_lsb8: assert property (p_lsb8) else $error("low byte driven in 8-bit mode");
   a_async_bus: assert property (p_async_bus) else $error("bus moved without read clock");
   a_sync_quiet: assert property (p_sync_quiet) else $error("valid with no pixel");
   a_dv_rise: assert property (p_dv_rise) else $error("valid rose on low fill");
   a_full: assert property (p_full) else $error("full and empty together");
   a_ptr_clear: assert property (p_ptr_clear) else $error("pointer clear left flags");
endmodule
bind pixel_output_fifo_port pixel_output_fifo_port_sva #(.DEPTH(DEPTH)) i_pixel_output_fifo_port_sva (
   .core_clk(core_clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .pix_valid(pix_valid), .video_data_bus(video_data_bus),
   .data_valid_flag(data_valid_flag), .almost_empty_flag(almost_empty_flag),
   .almost_full_flag(almost_full_flag), .fifo_read_clock(fifo_read_clock),
   .fifo_pointer_reset(fifo_pointer_reset));
`default_nettype wire

// ==== tb/pixel_output_fifo_port_tb.sv ====
// Purpose: self-checking bench of the pixel output fifo port
// Assumes: 40 MHz core clock, reader model on the fifo pins
// Notes:   flags are judged after each burst has settled
`timescale 1ns/10ps
`default_nettype none
module pixel_output_fifo_port_tb;
   import pixel_fifo_pkg::*;
   logic        core_clk, rst_b, cyc_i, stb_i, we_i, ack_o, irq, pix_valid, pix_ready, clr;
   logic        line_start_marker, field_start_marker, data_valid_flag, almost_empty_flag, almost_full_flag;
   logic        pixel_clock_1x, pixel_clock_2x, fifo_read_clock, fifo_read_enable, fifo_pointer_reset;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [15:0] pix_data, video_data_bus, wval;
   logic [15:0] expq[$];
   int          n_mismatch, n_checks, cycles;
   pixel_output_fifo_port i_pixel_output_fifo_port (.core_clk(core_clk), .rst_b(rst_b), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .irq(irq), .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
      .line_start_marker(line_start_marker), .field_start_marker(field_start_marker),
      .video_data_bus(video_data_bus), .data_valid_flag(data_valid_flag), .almost_empty_flag(almost_empty_flag),
      .almost_full_flag(almost_full_flag), .pixel_clock_1x(pixel_clock_1x), .pixel_clock_2x(pixel_clock_2x),
      .fifo_read_clock(fifo_read_clock), .fifo_read_enable(fifo_read_enable),
      .fifo_pointer_reset(fifo_pointer_reset));
   pixel_reader_model i_pixel_reader_model (.clr(clr), .fifo_read_clock(fifo_read_clock),
      .fifo_read_enable(fifo_read_enable), .fifo_pointer_reset(fifo_pointer_reset));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // =====================================================================
   // shared tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic flags(input logic dv, input logic ae, input logic af);
      chk("data valid", {31'h0, dv}, {31'h0, data_valid_flag});
      chk("almost empty", {31'h0, ae}, {31'h0, almost_empty_flag});
      chk("almost full", {31'h0, af}, {31'h0, almost_full_flag});
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge core_clk); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic send(input logic [15:0] w);
      @(posedge core_clk);
      pix_valid <= 1'b1;
      pix_data  <= w;
      do @(posedge core_clk); while (pix_ready !== 1'b1);
      pix_valid <= 1'b0;
   endtask
   task automatic push(input int n);
      repeat (n) begin
         send(wval);
         expq.push_back(wval);
         wval++;
      end
      repeat (8) @(posedge core_clk);
   endtask
   task automatic pop(input int n);
      repeat (n) begin
         i_pixel_reader_model.read_one();
         repeat (4) @(posedge core_clk);
         chk("fifo word", {16'h0, expq.pop_front()}, {16'h0, video_data_bus});
      end
      repeat (4) @(posedge core_clk);
   endtask
   task automatic see(input string what, input logic [15:0] b);
      int n;
      n = 0;
      while (video_data_bus !== b && n < 12) begin
         @(posedge core_clk);
         n++;
      end
      chk(what, {16'h0, b}, {16'h0, video_data_bus});
   endtask
   // =====================================================================
   // scenarios
   task automatic t_regs();
      wb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl reset", 32'h2, rd);
      wb(1'b1, 8'h10, 32'hFFFF_FFFF);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped read", 32'h0, rd);
      flags(1'b0, 1'b1, 1'b0);
      $display("regs test done");
   endtask
   task automatic t_async();
      wb(1'b1, REG_CTRL, 32'h03);
      wb(1'b1, REG_IRQ_MASK, 32'h01);
      push(18);
      flags(1'b0, 1'b0, 1'b0);
      line_start_marker <= 1'b1;
      @(posedge core_clk);
      line_start_marker  <= 1'b0;
      field_start_marker <= 1'b1;
      @(posedge core_clk);
      field_start_marker <= 1'b0;
      expq.push_back(CODE_LINE);
      expq.push_back(CODE_FIELD);
      repeat (8) @(posedge core_clk);
      flags(1'b1, 1'b0, 1'b0);
      push(12);
      flags(1'b1, 1'b0, 1'b0);
      chk("irq idle", 32'h0, {31'h0, irq});
      push(1);
      flags(1'b1, 1'b0, 1'b1);
      chk("irq raised", 32'h1, {31'h0, irq});
      wb(1'b0, REG_IRQ_STAT, 32'h0);
      chk("irq status", 32'h1, {31'h0, rd[0]});
      @(posedge core_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      pop(24);
      flags(1'b1, 1'b0, 1'b0);
      pop(1);
      flags(1'b1, 1'b1, 1'b0);
      chk("irq masked", 32'h0, {31'h0, irq});
      pop(8);
      flags(1'b0, 1'b1, 1'b0);
      $display("async test done");
   endtask
   task automatic t_thr();
      wb(1'b1, REG_CTRL, 32'h1B);
      push(19);
      flags(1'b0, 1'b0, 1'b0);
      push(1);
      flags(1'b0, 1'b0, 1'b1);
      push(12);
      flags(1'b1, 1'b0, 1'b1);
      clr <= 1'b1;
      repeat (2) @(posedge core_clk);
      clr <= 1'b0;
      repeat (2) @(posedge core_clk);
      expq.delete();
      flags(1'b0, 1'b1, 1'b0);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("status after clear", 32'h500, {20'h0, rd[11:0]});
      wb(1'b1, REG_CTRL, 32'h63);
      repeat (3) @(posedge core_clk);
      flags(1'b1, 1'b1, 1'b1);
      $display("threshold test done");
   endtask
   task automatic t_sync();
      wb(1'b1, REG_CTRL, 32'h02);
      repeat (4) @(posedge core_clk);
      send(16'hA5C3);
      see("sync word", 16'hA5C3);
      chk("clock 1x", 32'h1, {31'h0, pixel_clock_1x});
      @(posedge core_clk);
      chk("sync valid", 32'h1, {31'h0, data_valid_flag});
      repeat (8) @(posedge core_clk);
      chk("sync idle", 32'h0, {31'h0, data_valid_flag});
      wb(1'b1, REG_CTRL, 32'h00);
      send(16'h5AC3);
      see("high byte", 16'h5A00);
      chk("clock 2x", 32'h1, {31'h0, pixel_clock_2x});
      see("low byte", 16'hC300);
      wb(1'b1, REG_CTRL, 32'h06);
      line_start_marker <= 1'b1;
      @(posedge core_clk);
      line_start_marker <= 1'b0;
      see("line code", CODE_LINE);
      $display("sync test done");
   endtask
   initial begin
      rst_b = 1'b0;
      {cyc_i, stb_i, we_i, pix_valid, clr, line_start_marker, field_start_marker} = 7'h00;
      adr_i = 8'h00;
      sel_i = 4'hF;
      dat_i = 32'h0;
      pix_data = 16'h0;
      wval = 16'h1000;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      t_regs();
      t_async();
      t_thr();
      t_sync();
      stop_test();
   end
endmodule
`default_nettype wire

// ==== tb/pixel_reader_model.sv ====
// Purpose: capture-side reader of the output fifo
// Assumes: single reads on request, 200 ns read clock period
// Notes:   read clock stands low between reads
`timescale 1ns/10ps
`default_nettype none
module pixel_reader_model (
   // request from the bench
   input  wire logic clr,
   // fifo pins
   output logic      fifo_read_clock,
   output logic      fifo_read_enable,
   output logic      fifo_pointer_reset
);
   initial begin
      fifo_read_clock  = 1'b0;
      fifo_read_enable = 1'b0;
   end
   assign fifo_pointer_reset = !clr;
   // enable leads the clock so the synchronised pair sees it first
   task automatic read_one();
      fifo_read_enable <= 1'b1;
      #100 fifo_read_clock <= 1'b1;
      #100 fifo_read_clock <= 1'b0;
      fifo_read_enable <= 1'b0;
   endtask
endmodule
`default_nettype wire
